/* File: fsp_assertions.sv */
module fsp_poll_chk (
  // System
  input wire logic CLK,
  input wire logic SYS_RST,
  // Software port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Flash pins
  input wire logic CE_N,
  input wire logic OE_N,
  input wire logic WE_N,
  input wire logic [20:0] FA,
  input wire logic [7:0] DQ_O,
  input wire logic DQ_OE,
  input wire logic [7:0] DQ_I,
  input wire logic READY_BUSY_N
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // Strobe shape and bus hold
  chk_read_len: assert property (
    $fell(OE_N) |-> !OE_N [*4] ##1 OE_N) else $error("read strobe length");
  chk_addr_hold: assert property (
    !OE_N && !$past(OE_N) |-> $stable(FA)) else $error("address moved");
  chk_sel_strobe: assert property (
    !OE_N || !WE_N |-> !CE_N && (OE_N || WE_N)) else $error("bad select");
  chk_no_clash: assert property (
    DQ_OE |-> OE_N) else $error("bus contention");
  chk_wr_data: assert property (
    !WE_N && !$past(WE_N) |-> DQ_OE && $stable(DQ_O))
    else $error("write data unstable");
  chk_trail_gap: assert property (
    $rose(OE_N) |=> OE_N && WE_N) else $error("no trailing cycle");
  chk_unmapped_rd: assert property (
    RD && ADDR > 4'h4 |=> RDATA == 32'h0) else $error("unmapped not zero");
  chk_rst_idle: assert property (
    $past(SYS_RST) |-> CE_N && OE_N && WE_N && !DQ_OE)
    else $error("pins busy after reset");
  // Main scenarios reached
  cov_write: cover property ($fell(WE_N));
  cov_read: cover property ($fell(OE_N));
  cov_stat: cover property (RD && ADDR == 4'h3);
endmodule : fsp_poll_chk

bind fsp_poll_ctrl fsp_poll_chk u_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .FA(FA),
  .DQ_O(DQ_O), .DQ_OE(DQ_OE), .DQ_I(DQ_I), .READY_BUSY_N(READY_BUSY_N)
);

/* File: fsp_bus_cycle.sv */
// Runs one strobed read or write cycle on the flash pins
module fsp_bus_cycle (
  // System
  input wire logic clk,
  input wire logic rst,
  // Cycle request
  fsp_cyc_if.slave cyc,
  // Flash pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [20:0] addr_o,
  output logic [7:0] dq_o,
  output logic dq_oe,
  input wire logic [7:0] dq_sync
);
  logic [3:0] cnt_q;
  logic busy_q;
  logic [7:0] rdata_q;
  logic done_q;

  // Strobe phase counter; read data latched at strobe end
  always_ff @(posedge clk) begin
    done_q <= 1'b0;
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      dq_oe <= 1'b0;
      addr_o <= 21'h000000;
      dq_o <= 8'h00;
      rdata_q <= 8'h00;
    end else if (!busy_q && cyc.req) begin
      busy_q <= 1'b1;
      cnt_q <= 4'(fsp_pkg::STROBE_CYC + 2);
      addr_o <= cyc.addr;
      dq_o <= cyc.wdata;
      dq_oe <= cyc.wr;
      ce_n <= 1'b0;
      oe_n <= cyc.wr;
      we_n <= !cyc.wr;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) begin
        // Strobes rise; each read is a distinct cycle for toggles
        ce_n <= 1'b1;
        oe_n <= 1'b1;
        we_n <= 1'b1;
        rdata_q <= dq_sync;
      end else if (cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        dq_oe <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  assign cyc.done = done_q;
  assign cyc.rdata = rdata_q;
endmodule : fsp_bus_cycle

/* File: fsp_cyc_if.sv */
// Request and answer of one flash bus cycle
interface fsp_cyc_if;
  logic req;
  logic wr;
  logic [20:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport master (output req, wr, addr, wdata, input done, rdata);
  modport slave (input req, wr, addr, wdata, output done, rdata);
endinterface : fsp_cyc_if

/* File: fsp_flash_model.sv */
module fsp_flash_model (
  // Flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [20:0] fa,
  input wire logic [7:0] dq_o,
  // Device answers
  output logic [7:0] dq,
  output logic rb_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int left = 0;
  logic fail = 1'b0;
  logic erase = 1'b0;
  logic tog = 1'b0;
  logic [7:0] datum = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] wb = 8'h00;
  logic [20:0] ra = 21'h0;
  logic sel = 1'b0;
  logic susp = 1'b0;
  logic stog = 1'b0;
  logic [8:0] esec = 9'h000;
  logic [8:0] psec = 9'h1FF;
  // Status byte picked at each read
  always @(negedge oe_n) begin
    ra = fa;
    // Sector toggle flips on reads inside the selected sector
    if (sel && fa[20:12] == esec) stog = ~stog;
    if (left > 0 || fail) begin
      // Busy status from the first read after the command
      tog = ~tog;
      // Busy span counted in reads, also for protected targets
      if (left > 0) left = left - 1;
      last = {erase ? 1'b0 : ~datum[7], tog, fail && left == 0, 2'h0, stog,
              2'h0};
      // Reads in a protected sector give no valid status
      if (fa[20:12] == psec) last = ~datum;
    end else if (susp) begin
      // Erase suspend: toggle frozen, polarity bit high
      last = {1'b1, tog, 1'b0, 2'h0, stog, 2'h0};
    end else begin
      last = datum;
    end
  end
  // Released bus shows inverse of last byte
  assign dq = (!oe_n && !ce_n) ? last : ~last;
  // Open-drain busy level, stuck on failure
  assign rb_n = !(left > 0 || fail);
  // Reset command clears failed status
  always @(posedge we_n) begin
    wb = dq_o;
    if (dq_o == 8'hF0) fail = 1'b0;
  end
endmodule : fsp_flash_model

/* File: fsp_pkg.sv */
// Overview of operation
// - Host decides on the toggle bit; sector toggle bit only reported in status
// - Host polls at programmed or erasing address
// - Host reads twice and compares toggle bit
// - Timeout with toggling: recheck, then reset
// - Leaving polling restarts the procedure
// - Recheck polarity bit after timeout flag
// - Host writes reset after timeout failure
// - Reset is one write of F0
package fsp_pkg;
  // Software register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_STAT = 4'h3;
  localparam logic [3:0] REG_RDAT = 4'h4;
  // Control field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_RESET = 3;
  // Poll modes
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_POLAR = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_READ = 2'h3;
  // Status bit positions in the flash data byte
  localparam int BIT_POLAR = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_SECTOR = 2;
  // Reset command byte
  localparam logic [7:0] CMD_RESET = 8'hF0;
  // Bus timing
  localparam int CLK_MHZ = 20;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  // Result codes
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_DONE = 2'h1;
  localparam logic [1:0] RES_FAIL = 2'h2;
  typedef enum {
    ST_IDLE, ST_RD1, ST_RD2, ST_CHECK, ST_RST, ST_OK, ST_BAD
  } fsp_state_t;
endpackage : fsp_pkg

/* File: fsp_poll_ctrl.sv */
// Host side status poller for an embedded program or erase
//
// Our own choices: strobed register access and the address map.
module fsp_poll_ctrl (
  // System
  input wire logic CLK,
  input wire logic SYS_RST,
  // Software port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Flash pins
  output logic CE_N,
  output logic OE_N,
  output logic WE_N,
  output logic [20:0] FA,
  output logic [7:0] DQ_O,
  output logic DQ_OE,
  input wire logic [7:0] DQ_I,
  input wire logic READY_BUSY_N
);
  fsp_cyc_if cyc ();
  fsp_pkg::fsp_state_t st_q;
  logic [20:0] addr_q;
  logic [7:0] data_q;
  logic [1:0] mode_q;
  logic auto_rst_q;
  logic [7:0] first_q;
  logic [7:0] last_q;
  logic [1:0] res_q;
  logic recheck_q;
  logic sec_tog_q;
  logic [7:0] dq_s1_q, dq_s2_q;
  logic rb_s1_q, rb_s2_q;
  logic req_q;
  logic wr_q;
  logic [7:0] cyc_wdata;
  logic go;
  logic toggled;
  logic polar_ok;
  logic timeout;

  // Two-stage synchronisers for flash inputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= DQ_I;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= READY_BUSY_N;
      rb_s2_q <= rb_s1_q;
    end
  end

  fsp_bus_cycle u_cycle (
    .clk(CLK),
    .rst(SYS_RST),
    .cyc(cyc.slave),
    .ce_n(CE_N),
    .oe_n(OE_N),
    .we_n(WE_N),
    .addr_o(FA),
    .dq_o(DQ_O),
    .dq_oe(DQ_OE),
    .dq_sync(dq_s2_q)
  );

  assign go = WR && ADDR == fsp_pkg::REG_CTRL && WDATA[fsp_pkg::CTRL_GO];
  // Toggle compare between two back-to-back reads
  assign toggled = first_q[fsp_pkg::BIT_TOGGLE] !=
                   cyc.rdata[fsp_pkg::BIT_TOGGLE];
  assign polar_ok = cyc.rdata[fsp_pkg::BIT_POLAR] ==
                    data_q[fsp_pkg::BIT_POLAR];
  assign timeout = cyc.rdata[fsp_pkg::BIT_TIMEOUT];
  assign cyc_wdata = (st_q == fsp_pkg::ST_RST) ? fsp_pkg::CMD_RESET
                                                : data_q;

  // Software writable setup
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      addr_q <= 21'h000000;
      data_q <= 8'h00;
      mode_q <= fsp_pkg::MODE_TOGGLE;
      auto_rst_q <= 1'b1;
    end else if (WR) begin
      if (ADDR == fsp_pkg::REG_ADDR) addr_q <= WDATA[20:0];
      if (ADDR == fsp_pkg::REG_DATA) data_q <= WDATA[7:0];
      if (ADDR == fsp_pkg::REG_CTRL) begin
        mode_q <= WDATA[fsp_pkg::CTRL_MODE +: 2];
        auto_rst_q <= WDATA[fsp_pkg::CTRL_RESET];
      end
    end
  end

  // Polling sequencer; a new start always begins at the first read
  always_ff @(posedge CLK) begin
    req_q <= 1'b0;
    if (SYS_RST) begin
      st_q <= fsp_pkg::ST_IDLE;
      wr_q <= 1'b0;
      recheck_q <= 1'b0;
      first_q <= 8'h00;
      last_q <= 8'h00;
      res_q <= fsp_pkg::RES_NONE;
      sec_tog_q <= 1'b0;
    end else begin
      unique case (st_q)
        fsp_pkg::ST_IDLE, fsp_pkg::ST_OK, fsp_pkg::ST_BAD: begin
          if (go) begin
            st_q <= fsp_pkg::ST_RD1;
            recheck_q <= 1'b0;
            res_q <= fsp_pkg::RES_NONE;
            // Mode written with this start decides the first cycle
            wr_q <= WDATA[fsp_pkg::CTRL_MODE +: 2] == fsp_pkg::MODE_WRITE;
            req_q <= 1'b1;
          end
        end
        fsp_pkg::ST_RD1: begin
          if (cyc.done) begin
            first_q <= cyc.rdata;
            last_q <= cyc.rdata;
            if (mode_q == fsp_pkg::MODE_WRITE ||
                mode_q == fsp_pkg::MODE_READ) begin
              st_q <= fsp_pkg::ST_OK;
              res_q <= fsp_pkg::RES_DONE;
            end else if (mode_q == fsp_pkg::MODE_POLAR) begin
              // Polarity poll: second match means done, else check timeout
              if (polar_ok && !recheck_q) begin
                // One more read so lower bits are settled
                recheck_q <= 1'b1;
                req_q <= 1'b1;
              end else if (polar_ok) begin
                st_q <= fsp_pkg::ST_OK;
                res_q <= fsp_pkg::RES_DONE;
              end else if (timeout) begin
                st_q <= fsp_pkg::ST_CHECK;
                req_q <= 1'b1;
              end else begin
                req_q <= 1'b1;
              end
            end else begin
              st_q <= fsp_pkg::ST_RD2;
              req_q <= 1'b1;
            end
          end
        end
        fsp_pkg::ST_RD2: begin
          if (cyc.done) begin
            last_q <= cyc.rdata;
            sec_tog_q <= first_q[fsp_pkg::BIT_SECTOR] !=
                         cyc.rdata[fsp_pkg::BIT_SECTOR];
            first_q <= cyc.rdata;
            if (!toggled) begin
              // Stopped: operation complete
              st_q <= fsp_pkg::ST_OK;
              res_q <= fsp_pkg::RES_DONE;
            end else if (recheck_q) begin
              st_q <= auto_rst_q ? fsp_pkg::ST_RST : fsp_pkg::ST_BAD;
              res_q <= fsp_pkg::RES_FAIL;
              wr_q <= auto_rst_q;
              req_q <= auto_rst_q;
            end else begin
              recheck_q <= timeout;
              req_q <= 1'b1;
            end
          end
        end
        fsp_pkg::ST_CHECK: begin
          if (cyc.done) begin
            last_q <= cyc.rdata;
            if (polar_ok) begin
              st_q <= fsp_pkg::ST_OK;
              res_q <= fsp_pkg::RES_DONE;
            end else begin
              st_q <= auto_rst_q ? fsp_pkg::ST_RST : fsp_pkg::ST_BAD;
              res_q <= fsp_pkg::RES_FAIL;
              wr_q <= auto_rst_q;
              req_q <= auto_rst_q;
            end
          end
        end
        fsp_pkg::ST_RST: begin
          // Reset command written after a failure
          if (cyc.done) begin
            st_q <= fsp_pkg::ST_BAD;
            wr_q <= 1'b0;
          end
        end
      endcase
    end
  end

  assign cyc.req = req_q;
  assign cyc.wr = wr_q;
  assign cyc.addr = addr_q;
  assign cyc.wdata = cyc_wdata;

  // Read port: data one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      unique case (ADDR)
        fsp_pkg::REG_CTRL: RDATA <= {28'h0000000, auto_rst_q, mode_q, 1'b0};
        fsp_pkg::REG_ADDR: RDATA <= {11'h000, addr_q};
        fsp_pkg::REG_DATA: RDATA <= {24'h000000, data_q};
        fsp_pkg::REG_STAT: RDATA <= {26'h0, sec_tog_q,
                                     !rb_s2_q,
                                     res_q,
                                     st_q == fsp_pkg::ST_IDLE ||
                                     st_q == fsp_pkg::ST_OK ||
                                     st_q == fsp_pkg::ST_BAD,
                                     1'b0};
        fsp_pkg::REG_RDAT: RDATA <= {24'h000000, last_q};
        default: RDATA <= 32'h00000000;
      endcase
    end
  end
endmodule : fsp_poll_ctrl

/* File: testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic ce_n, oe_n, we_n, dq_oe, rb_n;
  logic [20:0] fa;
  logic [7:0] dq_o, fdq, dq_i;
  int mismatches = 0;
  int samples_checked = 0;
  // Clock and data bus resolution
  always #25 clk = ~clk;
  assign dq_i = dq_oe ? dq_o : fdq;
  fsp_poll_ctrl dut (
    .CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .FA(fa),
    .DQ_O(dq_o), .DQ_OE(dq_oe), .DQ_I(dq_i), .READY_BUSY_N(rb_n)
  );
  fsp_flash_model m (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .fa(fa), .dq_o(dq_o), .dq(fdq),
    .rb_n(rb_n)
  );
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  // Register write then one idle cycle
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  // Register read, data taken in the following cycle
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg
  // Start a job with auto reset, poll until idle
  task automatic run(input logic [1:0] mode, output logic [31:0] st);
    wr_reg(fsp_pkg::REG_CTRL, {28'h0, 1'b1, mode, 1'b1});
    st = 32'h0;
    for (int i = 0; i < 500 && st[1] !== 1'b1; i++)
      rd_reg(fsp_pkg::REG_STAT, st);
  endtask : run
  task automatic t_reset;
    logic [31:0] v;
    rd_reg(fsp_pkg::REG_STAT, v);
    chk(v[4:1], 4'h1);
    rd_reg(4'h9, v);
    chk(v, 32'h0);
    $display("t_reset finished");
  endtask : t_reset
  task automatic t_toggle_ok;
    logic [31:0] v;
    m.datum = 8'h5A;
    m.left = 4;
    run(fsp_pkg::MODE_TOGGLE, v);
    chk(v[5:1], 5'h03);
    rd_reg(fsp_pkg::REG_RDAT, v);
    chk(v, 32'h5A);
    $display("t_toggle_ok finished");
  endtask : t_toggle_ok
  task automatic t_toggle_fail;
    logic [31:0] v;
    m.fail = 1'b1;
    m.left = 2;
    run(fsp_pkg::MODE_TOGGLE, v);
    chk(v[3:1], 3'h5);
    chk(m.fail, 1'b0);
    chk(m.wb, fsp_pkg::CMD_RESET);
    $display("t_toggle_fail finished");
  endtask : t_toggle_fail
  task automatic t_polar(input logic er, input logic [7:0] d);
    logic [31:0] v;
    m.erase = er;
    m.datum = d;
    m.left = 3;
    wr_reg(fsp_pkg::REG_DATA, {24'h0, d});
    wr_reg(fsp_pkg::REG_ADDR, 32'h0ABCD);
    run(fsp_pkg::MODE_POLAR, v);
    chk(v[3:1], 3'h3);
    chk(m.ra, 21'h0ABCD);
    rd_reg(fsp_pkg::REG_RDAT, v);
    chk(v, {24'h0, d});
    $display("t_polar finished");
  endtask : t_polar
  task automatic t_suspend;
    logic [31:0] v;
    m.susp = 1'b1;
    m.sel = 1'b1;
    m.esec = 9'h00A;
    run(fsp_pkg::MODE_TOGGLE, v);
    chk(v[5:1], 5'h13);
    rd_reg(fsp_pkg::REG_RDAT, v);
    chk(v[7], 1'b1);
    m.susp = 1'b0;
    m.sel = 1'b0;
    m.stog = 1'b0;
    $display("t_suspend finished");
  endtask : t_suspend
  task automatic t_single;
    logic [31:0] v;
    m.erase = 1'b0;
    m.datum = 8'hC3;
    wr_reg(fsp_pkg::REG_DATA, 32'h3C);
    run(fsp_pkg::MODE_WRITE, v);
    chk(m.wb, 8'h3C);
    run(fsp_pkg::MODE_READ, v);
    rd_reg(fsp_pkg::REG_RDAT, v);
    chk(v, 32'hC3);
    $display("t_single finished");
  endtask : t_single
  task automatic t_pin;
    logic [31:0] v;
    m.left = 1000;
    rd_reg(fsp_pkg::REG_STAT, v);
    rd_reg(fsp_pkg::REG_STAT, v);
    chk(v[4], 1'b1);
    m.left = 0;
    rd_reg(fsp_pkg::REG_STAT, v);
    rd_reg(fsp_pkg::REG_STAT, v);
    chk(v[4], 1'b0);
    $display("t_pin finished");
  endtask : t_pin
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim;
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_toggle_ok;
    t_toggle_fail;
    t_polar(1'b0, 8'h80);
    t_polar(1'b1, 8'hFF);
    t_suspend;
    t_single;
    t_pin;
    end_sim;
  end
endmodule : testbench
